// *** core/arpc_top.sv ***
/*
 reference and pin control: a software register that steers the converter
 reference routing, channel switches and input halving, with a read-only
 status word. reference changes open all reference switches for a short
 break before the new routing is made.
 assumes a single 40 MHz clock, a synchronous active-high reset and pin
 driver settings delivered by logic on the same clock.
*/
// Local design decisions: the register offsets and the address-and-strobe port.
`include "arpc_defines.svh"

module arpc_top
    import arpc_pkg::*;
#(
    parameter int BREAK_CYCLES = `ARPC_BREAK_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // register port
    input wire logic [`ARPC_ADDR_W-1:0] addr_in,
    input wire logic [`ARPC_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [`ARPC_DATA_W-1:0] rdata_out,
    // pin driver settings from the output control logic
    input wire logic [3:0] pin_output_enable_in,
    input wire logic [3:0] pin_output_value_in,
    // reference routing
    output arpc_ref_src_t ref_src_out,
    output logic ref_connect_out,
    output logic [3:0] ref_pos_pin_out,
    output logic [3:0] ref_neg_pin_out,
    output logic ref_buffer_enable_out,
    // channel switches
    output logic supply_switch_out,
    output logic ch0_ground_out,
    output logic ch1_divider_out,
    output logic half_sample_out
);
    localparam logic [`ARPC_CNT_W-1:0] BREAK_LOAD = `ARPC_CNT_W'(BREAK_CYCLES - 1);

    function automatic logic field(input logic [`ARPC_DATA_W-1:0] word, input int pos);
        field = word[pos];
    endfunction

    // control register
    logic [`ARPC_DATA_W-1:0] ctrl_reg;
    logic [`ARPC_DATA_W-1:0] ctrl_next;
    // reads return the register word in the next cycle only
    logic [`ARPC_DATA_W-1:0] rdata_reg;
    logic [`ARPC_DATA_W-1:0] rdata_next;
    logic [`ARPC_DATA_W-1:0] status_word;

    // routing state
    arpc_state_t state_reg;
    arpc_state_t state_next;
    logic [`ARPC_CNT_W-1:0] cnt_reg;
    logic [`ARPC_CNT_W-1:0] cnt_next;
    arpc_ref_src_t src_reg;
    arpc_ref_src_t src_next;
    logic [3:0] pos_reg;
    logic [3:0] pos_next;
    logic [3:0] neg_reg;
    logic [3:0] neg_next;
    logic connect_reg;
    logic connect_next;

    // switch outputs
    logic buf_reg;
    logic buf_next;
    logic supply_reg;
    logic supply_next;
    logic gnd_reg;
    logic gnd_next;
    logic half_reg;
    logic half_next;

    // routing target
    arpc_axis_t panel_axis;
    logic [3:0] panel_pos;
    logic [3:0] panel_neg;
    arpc_ref_src_t tgt_src;
    logic [3:0] tgt_pos;
    logic [3:0] tgt_neg;
    logic tgt_differs;
    logic buf_warn;
    logic meas_warn;

    arpc_panel_decode u_panel (
        .pin_output_enable_in(pin_output_enable_in),
        .pin_output_value_in(pin_output_value_in),
        .axis_out(panel_axis),
        .pos_pin_out(panel_pos),
        .neg_pin_out(panel_neg)
    );

    // register access
    always_comb begin
        ctrl_next = ctrl_reg;
        // reserved bits are masked on write so they always read zero
        if (wr_in && addr_in == `ARPC_OFS_CTRL) begin
            ctrl_next = wdata_in & `ARPC_CTRL_WMASK;
        end
        rdata_next = '0;
        if (rd_in) begin
            case (addr_in)
                `ARPC_OFS_CTRL: rdata_next = ctrl_reg;
                `ARPC_OFS_STATUS: rdata_next = status_word;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_reg <= `ARPC_CTRL_RESET;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // reference target
    always_comb begin
        tgt_src = ARPC_SRC_BG_LOW;
        tgt_pos = 4'h0;
        tgt_neg = 4'h0;
        if (field(ctrl_reg, `ARPC_BIT_PANEL)) begin
            // supply select is not looked at here
            tgt_src = ARPC_SRC_PANEL;
            tgt_pos = panel_pos;
            tgt_neg = panel_neg;
        end else if (field(ctrl_reg, `ARPC_BIT_REFSUP)) begin
            tgt_src = ARPC_SRC_SUPPLY;
        end else if (field(ctrl_reg, `ARPC_BIT_BGLVL)) begin
            tgt_src = ARPC_SRC_BG_HIGH;
        end else begin
            tgt_src = ARPC_SRC_BG_LOW;
        end
        tgt_differs = (tgt_src != src_reg) || (tgt_pos != pos_reg) || (tgt_neg != neg_reg);
        // advisory flags only: hardware does not override software here
        buf_warn = !field(ctrl_reg, `ARPC_BIT_BUFEN)
            && (tgt_src == ARPC_SRC_BG_LOW || tgt_src == ARPC_SRC_BG_HIGH);
        meas_warn = field(ctrl_reg, `ARPC_BIT_SUPPLY)
            && (tgt_src == ARPC_SRC_SUPPLY || !field(ctrl_reg, `ARPC_BIT_HALF));
    end

    // routing state machine: break before make so two sources never short
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        src_next = src_reg;
        pos_next = pos_reg;
        neg_next = neg_reg;
        connect_next = connect_reg;
        case (state_reg)
            ARPC_ROUTED: begin
                if (tgt_differs) begin
                    state_next = ARPC_SETTLING;
                    cnt_next = BREAK_LOAD;
                    connect_next = 1'b0;
                    pos_next = 4'h0;
                    neg_next = 4'h0;
                    src_next = tgt_src;
                end else begin
                    connect_next = 1'b1;
                end
            end
            ARPC_SETTLING: begin
                // a target source that moves during the break restarts the wait
                if (tgt_src != src_reg) begin
                    src_next = tgt_src;
                    cnt_next = BREAK_LOAD;
                end else if (cnt_reg == '0) begin
                    state_next = ARPC_ROUTED;
                    pos_next = tgt_pos;
                    neg_next = tgt_neg;
                    connect_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ARPC_SETTLING;
                cnt_next = BREAK_LOAD;
                connect_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= ARPC_SETTLING;
            cnt_reg <= BREAK_LOAD;
            src_reg <= ARPC_SRC_BG_LOW;
            pos_reg <= 4'h0;
            neg_reg <= 4'h0;
            connect_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            src_reg <= src_next;
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            connect_reg <= connect_next;
        end
    end

    // channel switches follow the register one cycle later
    always_comb begin
        buf_next = field(ctrl_reg, `ARPC_BIT_BUFEN);
        supply_next = field(ctrl_reg, `ARPC_BIT_SUPPLY);
        gnd_next = field(ctrl_reg, `ARPC_BIT_GND);
        half_next = field(ctrl_reg, `ARPC_BIT_HALF);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            buf_reg <= 1'b0;
            supply_reg <= 1'b0;
            gnd_reg <= 1'b0;
            half_reg <= 1'b0;
        end else begin
            buf_reg <= buf_next;
            supply_reg <= supply_next;
            gnd_reg <= gnd_next;
            half_reg <= half_next;
        end
    end

    // status word
    always_comb begin
        status_word = '0;
        status_word[`ARPC_ST_SRC_LO +: 2] = src_reg;
        status_word[`ARPC_ST_AXIS_LO +: 2] = panel_axis;
        status_word[`ARPC_ST_SETTLE] = (state_reg == ARPC_SETTLING);
        status_word[`ARPC_ST_BUF_WARN] = buf_warn;
        status_word[`ARPC_ST_MEAS_WARN] = meas_warn;
        status_word[`ARPC_ST_POS_LO +: 4] = pos_reg;
        status_word[`ARPC_ST_NEG_LO +: 4] = neg_reg;
    end

    assign rdata_out = rdata_reg;
    assign ref_src_out = src_reg;
    assign ref_connect_out = connect_reg;
    assign ref_pos_pin_out = pos_reg;
    assign ref_neg_pin_out = neg_reg;
    assign ref_buffer_enable_out = buf_reg;
    assign supply_switch_out = supply_reg;
    // the divider on channel 1 is switched together with the channel 0 ground
    assign ch0_ground_out = gnd_reg;
    assign ch1_divider_out = gnd_reg;
    assign half_sample_out = half_reg;
endmodule

// *** core/arpc_defines.svh ***
/*
 holds the register offsets, field positions, reset values and timing counts
 of the reference and pin control block.
 assumes it is included by bare name from files under core/.
*/
`ifndef ARPC_DEFINES_SVH
`define ARPC_DEFINES_SVH

`define ARPC_ADDR_W 4
`define ARPC_DATA_W 16
`define ARPC_OFS_CTRL 4'h0
`define ARPC_OFS_STATUS 4'h1

`define ARPC_BIT_HALF 0
`define ARPC_BIT_GND 1
`define ARPC_BIT_SUPPLY 3
`define ARPC_BIT_PANEL 4
`define ARPC_BIT_REFSUP 8
`define ARPC_BIT_BGLVL 9
`define ARPC_BIT_BUFEN 10
`define ARPC_CTRL_WMASK 16'h071B
`define ARPC_CTRL_RESET 16'h0000

`define ARPC_ST_SRC_LO 0
`define ARPC_ST_AXIS_LO 2
`define ARPC_ST_SETTLE 4
`define ARPC_ST_BUF_WARN 5
`define ARPC_ST_MEAS_WARN 6
`define ARPC_ST_POS_LO 8
`define ARPC_ST_NEG_LO 12

`define ARPC_CLK_PERIOD_NS 25
`define ARPC_BREAK_NS 100
`define ARPC_BREAK_CYCLES ((`ARPC_BREAK_NS + `ARPC_CLK_PERIOD_NS - 1) / `ARPC_CLK_PERIOD_NS)
`define ARPC_CNT_W 8

`endif

// *** core/arpc_pkg.sv ***
/*
 holds the types of the reference and pin control block.
 assumes nothing beyond a SystemVerilog compiler.
*/
package arpc_pkg;
    typedef enum logic [1:0] {
        ARPC_SRC_BG_LOW,
        ARPC_SRC_BG_HIGH,
        ARPC_SRC_SUPPLY,
        ARPC_SRC_PANEL
    } arpc_ref_src_t;

    typedef enum logic [1:0] {
        ARPC_AXIS_NONE,
        ARPC_AXIS_X,
        ARPC_AXIS_Y
    } arpc_axis_t;

    typedef enum logic [0:0] {
        ARPC_ROUTED,
        ARPC_SETTLING
    } arpc_state_t;
endpackage

// *** core/arpc_panel_decode.sv ***
/*
 combinational decode of the pin driver settings into the measured panel
 axis and the pins that carry the reference terminals.
 assumes pin enables and values come from logic on the same clock.
*/
`include "arpc_defines.svh"

module arpc_panel_decode
    import arpc_pkg::*;
(
    // pin driver settings
    input wire logic [3:0] pin_output_enable_in,
    input wire logic [3:0] pin_output_value_in,
    // decoded routing
    output arpc_axis_t axis_out,
    output logic [3:0] pos_pin_out,
    output logic [3:0] neg_pin_out
);
    // a pair drives the panel when both pins are outputs at opposite levels
    function automatic logic pair_driven(input logic [1:0] oe, input logic [1:0] val);
        pair_driven = oe[0] & oe[1] & (val[0] ^ val[1]);
    endfunction

    logic x_drive;
    logic y_drive;

    always_comb begin
        x_drive = pair_driven(pin_output_enable_in[1:0], pin_output_value_in[1:0]);
        y_drive = pair_driven(pin_output_enable_in[3:2], pin_output_value_in[3:2]);
        axis_out = ARPC_AXIS_NONE;
        pos_pin_out = 4'h0;
        neg_pin_out = 4'h0;
        // both pairs driven is ambiguous: leave the terminals open
        if (x_drive && !y_drive) begin
            axis_out = ARPC_AXIS_X;
            pos_pin_out = {2'b00, pin_output_value_in[1:0]};
            neg_pin_out = {2'b00, ~pin_output_value_in[1:0]};
        end else if (y_drive && !x_drive) begin
            axis_out = ARPC_AXIS_Y;
            pos_pin_out = {pin_output_value_in[3:2], 2'b00};
            neg_pin_out = {~pin_output_value_in[3:2], 2'b00};
        end
    end
endmodule

// *** tb/arpc_assertions.sv ***
/*
 port checker of the reference and pin control block.
 assumes it is bound to arpc_top, one clock, synchronous active-high reset.
*/
`include "arpc_defines.svh"

module arpc_checker
    import arpc_pkg::*;
#(
    parameter int BREAK_CYCLES = 4
) (
    // clock, reset and register port
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    // routing and switches
    input wire arpc_ref_src_t ref_src_out,
    input wire logic ref_connect_out,
    input wire logic [3:0] ref_pos_pin_out,
    input wire logic [3:0] ref_neg_pin_out,
    input wire logic supply_switch_out,
    input wire logic ch0_ground_out,
    input wire logic ch1_divider_out,
    input wire logic half_sample_out
);
    logic wr_ctrl;
    assign wr_ctrl = wr_in && addr_in == `ARPC_OFS_CTRL;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    supply_switch_a: assert property (
        wr_ctrl |-> ##2 supply_switch_out == $past(wdata_in[3], 2))
        else $error("supply switch does not follow write");
    half_sample_a: assert property (
        wr_ctrl |-> ##2 half_sample_out == $past(wdata_in[0], 2))
        else $error("halving does not follow write");
    ground_divider_a: assert property (
        wr_ctrl |-> ##2 ch0_ground_out == $past(wdata_in[1], 2) && ch1_divider_out == ch0_ground_out)
        else $error("ground or divider does not follow write");
    read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read slot");
    reserved_zero_a: assert property (
        $past(rd_in && addr_in == `ARPC_OFS_CTRL) |-> (rdata_out & 16'hF8E4) == 16'h0000)
        else $error("reserved control bits read nonzero");
    panel_source_a: assert property (
        wr_ctrl && wdata_in[4] |-> ##2 ref_src_out == ARPC_SRC_PANEL)
        else $error("panel mode not routed");
    ref_source_a: assert property (
        wr_ctrl && !wdata_in[4] |-> ##2 ref_src_out == ($past(wdata_in[8], 2) ? ARPC_SRC_SUPPLY
        : $past(wdata_in[9], 2) ? ARPC_SRC_BG_HIGH : ARPC_SRC_BG_LOW))
        else $error("wrong reference source");
    route_break_a: assert property ($changed(ref_src_out) |-> !ref_connect_out)
        else $error("source changed with switches closed");
    break_length_a: assert property (
        $rose(ref_connect_out) |-> $past(ref_connect_out, BREAK_CYCLES) == 1'b0)
        else $error("break too short");
    pins_off_a: assert property (
        ref_src_out != ARPC_SRC_PANEL |-> ref_pos_pin_out == 4'h0 && ref_neg_pin_out == 4'h0)
        else $error("panel pins routed outside panel mode");

    cover property (wr_ctrl && wdata_in[4]);
    cover property ($rose(ref_connect_out));
    cover property ($past(rd_in) && rdata_out != 16'h0000);
endmodule

bind arpc_top arpc_checker #(.BREAK_CYCLES(BREAK_CYCLES)) u_chk (.clock_in(clock_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ref_src_out(ref_src_out), .ref_connect_out(ref_connect_out),
    .ref_pos_pin_out(ref_pos_pin_out), .ref_neg_pin_out(ref_neg_pin_out),
    .supply_switch_out(supply_switch_out), .ch0_ground_out(ch0_ground_out),
    .ch1_divider_out(ch1_divider_out), .half_sample_out(half_sample_out));

// *** tb/arpc_tb_top.sv ***
/*
 self-checking bench of the reference and pin control block.
 assumes the default break length of four cycles.
*/
module arpc_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [15:0] c;
        logic [3:0] en, val;
        logic [1:0] src;
        logic [3:0] p, n;
    } arpc_row_t;
    logic clock_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0, pen = 4'h0, pval = 4'h0, pos, neg;
    logic [15:0] wdata_in = 16'h0000, rdata_out, d, c;
    logic [1:0] src;
    logic conn, bufen, sup, gnd, div, half;
    int n_mismatch = 0, checked = 0, cycles = 0, i;
    // pin routes: pins 0/1 give one axis, 2/3 the other; both or none driven gives no route
    arpc_row_t rows[10] = '{
        '{16'h0400, 4'h0, 4'h0, 2'h0, 4'h0, 4'h0}, '{16'h0600, 4'h0, 4'h0, 2'h1, 4'h0, 4'h0},
        '{16'h0100, 4'h0, 4'h0, 2'h2, 4'h0, 4'h0}, '{16'h0300, 4'h0, 4'h0, 2'h2, 4'h0, 4'h0},
        '{16'h0110, 4'h3, 4'h1, 2'h3, 4'h1, 4'h2}, '{16'h0010, 4'hC, 4'h8, 2'h3, 4'h8, 4'h4},
        '{16'h0010, 4'h3, 4'h2, 2'h3, 4'h2, 4'h1}, '{16'h0010, 4'hF, 4'h5, 2'h3, 4'h0, 4'h0},
        '{16'h0409, 4'h0, 4'h0, 2'h0, 4'h0, 4'h0}, '{16'hFFDF, 4'h0, 4'h0, 2'h3, 4'h0, 4'h0}};

    arpc_top dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_output_enable_in(pen),
        .pin_output_value_in(pval), .ref_src_out(src), .ref_connect_out(conn),
        .ref_pos_pin_out(pos), .ref_neg_pin_out(neg), .ref_buffer_enable_out(bufen),
        .supply_switch_out(sup), .ch0_ground_out(gnd), .ch1_divider_out(div),
        .half_sample_out(half));

    initial begin
        forever #12.5 clock_in = ~clock_in;
    end

    task final_report;
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hang ends the run as a failure
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            final_report;
        end
    end

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask

    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        #1 check("reset outputs", {conn, src, pos, neg, bufen, sup, gnd, div, half},
            16'h0000);
        rd(4'h0, d);
        check("ctrl reset", d, 16'h0000);
        repeat (8) @(posedge clock_in);
        // routing opens for the break before the new source is connected
        wr(4'h0, 16'h0100);
        @(posedge clock_in);
        #1 check("break start", {13'h0000, conn, src}, 16'h0002);
        repeat (3) @(posedge clock_in);
        #1 check("break end", {15'h0000, conn}, 16'h0000);
        @(posedge clock_in);
        #1 check("reconnect", {15'h0000, conn}, 16'h0001);
        // write followed at once by a read
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= 4'h0;
        wdata_in <= 16'h0609;
        @(posedge clock_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 check("read after write", rdata_out, 16'h0609);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, d);
        check("unmapped read", d, 16'h0000);
        rd(4'h0, d);
        check("ctrl kept", d, 16'h0609);
        for (i = 0; i < 10; i++) begin
            c = rows[i].c;
            @(posedge clock_in);
            pen <= rows[i].en;
            pval <= rows[i].val;
            wr(4'h0, c);
            repeat (8) @(posedge clock_in);
            #1 check("source", {14'h0000, src}, {14'h0000, rows[i].src});
            check("pins", {8'h00, pos, neg}, {8'h00, rows[i].p, rows[i].n});
            check("switches", {10'h000, conn, bufen, sup, gnd, div, half},
                {10'h000, 1'b1, c[10], c[3], c[1], c[1], c[0]});
            rd(4'h0, d);
            check("readback", d, c & 16'h071B);
        end
        // a reset in mid-run clears routing, switches and the register
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1 check("reset again", {conn, src, pos, neg, bufen, sup, gnd, div, half},
            16'h0000);
        @(posedge clock_in);
        rst_in <= 1'b0;
        rd(4'h0, d);
        check("ctrl cleared", d, 16'h0000);
        // supply measurement set up as advised: bandgap, buffer on, halving
        wr(4'h0, 16'h0409);
        repeat (8) @(posedge clock_in);
        rd(4'h1, d);
        check("status settled", d, 16'h0000);
        // a source change shows the break in the status word at once
        wr(4'h0, 16'h0609);
        rd(4'h1, d);
        check("status break", d, 16'h0011);
        final_report;
    end
endmodule
